// *** keypad_level_interrupt.sv ***
// keypad level interrupt unit with its three special function registers
`include "keypad_defs.svh"

module keypad_level_interrupt
  import keypad_pkg::*;
#(
  parameter int SYNC_STAGES = `SYNC_DEPTH // synchroniser length
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire sfr_req_s sfr_req,
  output logic [7:0] sfr_rdata,
  input wire logic keypad_input_line,
  input wire logic keypad_irq_global_enable,
  output logic keypad_irq,
  output logic powerdown_wake,
  output logic [6:0] aux_shared_bits
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  // fewer than two stages would expose a metastable flop
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  // maps an address onto a register select
  function automatic reg_sel_e decode(input logic [7:0] a);
    reg_sel_e s;
    s = SEL_NONE;
    case (a)
      `AUX_CTRL_ADDR: s = SEL_AUX;
      `KP_CTRL_ADDR: s = SEL_CTRL;
      `KP_STAT_ADDR: s = SEL_STAT;
      default: s = SEL_NONE;
    endcase
    return s;
  endfunction

  reg_sel_e sel; // register addressed this cycle
  logic wr_ctrl; // write to control
  logic wr_stat; // write to status
  logic wr_aux; // write to auxiliary
  logic rd_stat; // read of status, clears the flag

  assign sel = decode(sfr_req.addr);
  assign wr_ctrl = sfr_req.wr && (sel == SEL_CTRL);
  assign wr_stat = sfr_req.wr && (sel == SEL_STAT);
  assign wr_aux = sfr_req.wr && (sel == SEL_AUX);
  assign rd_stat = sfr_req.rd && (sel == SEL_STAT);

  ////////////////////////////////////////////////////////////////////////////
  // input synchroniser

  logic [SYNC_STAGES-1:0] sync_chain; // [0] is read only by [1]
  logic input_sync; // clean copy of the keypad line

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      // idle line is high, so auxiliary bit 0 reads one after reset
      sync_chain <= '1;
    end else begin
      sync_chain <= {sync_chain[SYNC_STAGES-2:0], keypad_input_line};
    end
  end

  assign input_sync = sync_chain[SYNC_STAGES-1];

  ////////////////////////////////////////////////////////////////////////////
  // control register

  logic [7:0] kp_ctrl; // keypad control
  logic level_select; // level that counts as a key
  logic detect_irq_mask; // blocks the flag from the interrupt

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      kp_ctrl <= `KP_CTRL_RST;
    end else if (wr_ctrl) begin
      // software keeps bits 3:1 set, stored as written
      kp_ctrl <= sfr_req.wdata;
    end
  end

  assign level_select = kp_ctrl[`CTRL_LEVEL_BIT];
  assign detect_irq_mask = kp_ctrl[`CTRL_MASK_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // status register

  logic powerdown_wake_enable; // lets the keypad end power-down
  logic level_detect_flag; // sticky detection flag
  logic level_match; // synchronised line at chosen level

  assign level_match = (input_sync == level_select);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      powerdown_wake_enable <= 1'(`KP_STAT_RST >> `STAT_WAKE_BIT);
    end else if (wr_stat) begin
      powerdown_wake_enable <= sfr_req.wdata[`STAT_WAKE_BIT];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      level_detect_flag <= 1'b0;
    end else if (level_match) begin
      // set wins over a clearing read in the same cycle
      level_detect_flag <= 1'b1;
    end else if (rd_stat) begin
      level_detect_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // auxiliary register

  logic [6:0] aux_store; // bits owned by neighbouring blocks

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      // bit 0 of the reset value is the pin, not stored
      aux_store <= 7'(`AUX_CTRL_RST >> 1);
    end else if (wr_aux) begin
      aux_store <= sfr_req.wdata[7:1];
    end
  end

  assign aux_shared_bits = aux_store;

  ////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_req.rd) begin
      case (sel)
        // bit 0 shows the keypad line
        SEL_AUX: sfr_rdata <= {aux_store, input_sync};
        SEL_CTRL: sfr_rdata <= kp_ctrl;
        SEL_STAT: sfr_rdata <= {powerdown_wake_enable, 6'h00,
                                level_detect_flag};
        // unmapped addresses read zero
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt and wake outputs

  // mask gates the flag; global enable gates the core request
  assign keypad_irq = level_detect_flag && !detect_irq_mask
                      && keypad_irq_global_enable;

  // raw-pin wake, clocks may be stopped
  // asynchronous level detect, no synchroniser in this path
  assign powerdown_wake = powerdown_wake_enable && !detect_irq_mask
                          && (keypad_input_line == level_select);

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [1:0] age; // cycles since reset release, saturating
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      age <= 2'd0;
    end else if (age != 2'd3) begin
      age <= age + 2'd1;
    end
  end

  AST_MASK_BLOCKS: assert property (
    detect_irq_mask |-> !keypad_irq)
    else $error("masked flag raised interrupt");
  AST_UNMASK_RAISES: assert property (
    level_detect_flag && !detect_irq_mask && keypad_irq_global_enable
    |-> keypad_irq)
    else $error("unmasked flag gave no interrupt");
  AST_WAKE_GATED: assert property (
    !powerdown_wake_enable |-> !powerdown_wake)
    else $error("wake without enable");
  AST_RSVD_ZERO: assert property (
    rd_stat |=> sfr_rdata[6:1] == 6'h00)
    else $error("reserved status bits not zero");
  AST_RESET_VALUES: assert property (
    age == 2'd0 |-> kp_ctrl == `KP_CTRL_RST && !level_detect_flag
    && !powerdown_wake_enable && aux_store == 7'h7F)
    else $error("wrong register value after reset");
  AST_MATCH_SETS: assert property (
    level_match |=> level_detect_flag)
    else $error("level match did not set flag");
  AST_READ_CLEARS: assert property (
    rd_stat && !level_match |=> !level_detect_flag
    && sfr_rdata[0] == $past(level_detect_flag))
    else $error("status read did not clear flag");
  AST_GLOBAL_GATE: assert property (
    !keypad_irq_global_enable |-> !keypad_irq)
    else $error("interrupt passed without global enable");
  AST_SYNC_DELAY: assert property (
    age == 2'd3 |-> input_sync == $past(keypad_input_line, 2))
    else $error("synchroniser delay wrong");

  COV_IRQ: cover property (keypad_irq);
  COV_SET_ON_READ: cover property (rd_stat && level_match);
  COV_WAKE: cover property (powerdown_wake);
  COV_CLEAR: cover property (level_detect_flag ##1 !level_detect_flag);

endmodule // keypad_level_interrupt

// *** keypad_defs.svh ***
// constants for the keypad level interrupt unit
`ifndef KEYPAD_DEFS_SVH
`define KEYPAD_DEFS_SVH

// register offsets on the special function register port
`define AUX_CTRL_ADDR 8'h90
`define KP_CTRL_ADDR 8'hA3
`define KP_STAT_ADDR 8'hA4

// reset values
`define AUX_CTRL_RST 8'hFF
`define KP_CTRL_RST 8'h0F
`define KP_STAT_RST 8'h00

// field positions
`define AUX_INPUT_BIT 0
`define CTRL_LEVEL_BIT 4
`define CTRL_MASK_BIT 0
`define STAT_WAKE_BIT 7
`define STAT_FLAG_BIT 0

// synchroniser depth
`define SYNC_DEPTH 2

`endif

// *** keypad_pkg.sv ***
// types shared by the keypad level interrupt unit
package keypad_pkg;

  // one special function register access, as issued by the core
  typedef struct packed {
    logic [7:0] addr;  // register address
    logic wr;          // write strobe, one cycle
    logic rd;          // read strobe, one cycle
    logic [7:0] wdata; // write data
  } sfr_req_s;

  // which register an address selects
  typedef enum logic [3:0] {
    SEL_NONE = 4'b0001,
    SEL_AUX = 4'b0010,
    SEL_CTRL = 4'b0100,
    SEL_STAT = 4'b1000
  } reg_sel_e;

endpackage

// *** keypad_switch.sv ***
// behavioural keypad switch on the single keypad input line
module keypad_switch (
  input wire logic pressed,
  input wire logic press_level,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  // line has a pull-up, so a released key reads high
  assign line = pressed ? press_level : 1'b1;
endmodule // keypad_switch

// *** tb.sv ***
// self-checking bench for the keypad level interrupt unit
`include "keypad_defs.svh"
module tb import keypad_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk; // 50 MHz core clock
  logic sys_rst; // async reset
  sfr_req_s sfr_req; // register request
  logic [7:0] sfr_rdata;
  logic pressed; // switch command
  logic press_level; // level a press drives
  logic line; // keypad pin
  logic gen; // global enable
  logic keypad_irq;
  logic powerdown_wake;
  logic [6:0] aux_bits;
  int errors;
  int n_checks;
  ////////////////////////////////////////////////////////////////////
  always #10 clk = ~clk;
  keypad_level_interrupt u_keypad_level_interrupt (
    .clk(clk), .sys_rst(sys_rst), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .keypad_input_line(line),
    .keypad_irq_global_enable(gen), .keypad_irq(keypad_irq),
    .powerdown_wake(powerdown_wake), .aux_shared_bits(aux_bits)
  );
  keypad_switch u_keypad_switch (
    .pressed(pressed), .press_level(press_level), .line(line)
  );
  ////////////////////////////////////////////////////////////////////
  // compare and count, four-state exact
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // wait n edges, then step off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one-cycle write strobe, then one idle edge so that the next
  // access never raises a strobe in the step that lowers this one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    cyc(1);
    sfr_req.wr = 1'b0;
    cyc(1);
  endtask
  // one-cycle read strobe; data lands on that same edge and stands
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfr_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    cyc(1);
    sfr_req.rd = 1'b0;
    chk(sfr_rdata, exp);
    cyc(1);
  endtask
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  // watchdog: run needs about 60 cycles, allow far more
  initial begin
    #20us;
    errors++;
    report_and_stop();
  end
  // main sequence
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    sfr_req = '0;
    pressed = 1'b0;
    press_level = 1'b0;
    gen = 1'b1;
    errors = 0;
    n_checks = 0;
    cyc(2);
    sys_rst = 1'b0;
    cyc(3); // let the synchroniser settle
    rd(`AUX_CTRL_ADDR, 8'hFF);
    rd(`KP_CTRL_ADDR, 8'h0F);
    rd(`KP_STAT_ADDR, 8'h00);
    chk({1'b0, aux_bits}, 8'h7F);
    rd(8'h55, 8'h00);
    $display("test reset done");
    // low level detect, unmasked; reserved bits kept set
    wr(`KP_CTRL_ADDR, 8'h0E);
    pressed = 1'b1;
    cyc(4);
    chk({7'h00, keypad_irq}, 8'h01);
    rd(`AUX_CTRL_ADDR, 8'hFE);
    gen = 1'b0;
    cyc(1);
    chk({7'h00, keypad_irq}, 8'h00);
    gen = 1'b1;
    wr(`KP_CTRL_ADDR, 8'h0F);
    chk({7'h00, keypad_irq}, 8'h00);
    wr(`KP_CTRL_ADDR, 8'h0E);
    pressed = 1'b0;
    cyc(4);
    rd(`KP_STAT_ADDR, 8'h01);
    rd(`KP_STAT_ADDR, 8'h00);
    chk({7'h00, keypad_irq}, 8'h00);
    $display("test detect done");
    // high level detect, wake enable, reserved status bits
    wr(`KP_CTRL_ADDR, 8'h1E);
    cyc(3);
    rd(`KP_STAT_ADDR, 8'h01);
    wr(`KP_STAT_ADDR, 8'hFE);
    rd(`KP_STAT_ADDR, 8'h81);
    chk({7'h00, powerdown_wake}, 8'h01);
    pressed = 1'b1;
    cyc(1);
    chk({7'h00, powerdown_wake}, 8'h00);
    pressed = 1'b0;
    wr(`KP_CTRL_ADDR, 8'h1F);
    chk({7'h00, powerdown_wake}, 8'h00);
    wr(`KP_CTRL_ADDR, 8'h1E);
    chk({7'h00, powerdown_wake}, 8'h01);
    wr(`KP_STAT_ADDR, 8'h00);
    chk({7'h00, powerdown_wake}, 8'h00);
    $display("test wake done");
    // auxiliary storage, bit 0 stays the pin
    wr(`AUX_CTRL_ADDR, 8'h00);
    chk({1'b0, aux_bits}, 8'h00);
    rd(`AUX_CTRL_ADDR, 8'h01);
    $display("test aux done");
    report_and_stop();
  end
endmodule // tb
